// >>> hdl/csc_core.sv
// Codec serial cascade core: clocking, serial port, cascade chain, sinc filters
`timescale 1ns/1ns
`default_nettype none
`include "csc_consts.svh"
//
// Contract
// - Decoder updates once every 256 master clocks, same as encoder rate.
// - Encoder decimates modulator bitstream with sinc3, factor 32.
// - Decoder interpolates with sinc3, factor 32, at modulator rate.
// - Bypass feeds DAC word straight to modulator input, repeated.
// - DAC word holds between host updates; conversion keeps running.
// - With reset on system reset, mixed mode gives the software reset.
// - All cascaded devices make serial clock of same frequency and phase.
// - Preamp enabled and set from three-bit input gain select.
// - Count frame syncs against cascade length to pick the DAC word.
// - 16-bit words, active-high frame sync one bit before MSB.
module csc_core
  import csc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       serial_data_in,
  input  wire logic       in_frame_sync,
  input  wire logic       port_enable_pin,
  input  wire logic       device_reset_n,
  input  wire logic       adc_bitstream,
  input  wire logic [2:0] input_gain_select,
  input  wire logic [2:0] cascade_length_field,
  input  wire logic       interp_bypass,
  input  wire logic       mixed_mode,
  input  wire logic       soft_reset_req,
  output logic            serial_clock,
  output logic            serial_data_out,
  output logic            out_frame_sync,
  output var csc_word_t   dsm_input,
  output logic            dsm_strobe,
  output logic            preamp_enable,
  output logic [2:0]      preamp_gain
);
  logic [3:0] sync1_r, sync2_r, sync3_r, pin_r;
  logic       sdi_q, ifs_q, pen_q, dev_rst_q, clr;
  logic [2:0] mclk_cnt_r;
  logic [7:0] mclk_idx_r;
  logic       mclk_en, mod_en, sample_en, sclk_rise, sclk_fall;

  // Pins pass three flops; a level counts once the last two agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // Idle as enabled and out of reset, so no false clear or frame sync follows reset
      sync1_r <= `CSC_PIN_IDLE;
      sync2_r <= `CSC_PIN_IDLE;
      sync3_r <= `CSC_PIN_IDLE;
      pin_r   <= `CSC_PIN_IDLE;
    end else begin
      sync1_r <= {serial_data_in, in_frame_sync, port_enable_pin, device_reset_n} ^ 4'h0;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (int i = 0; i < 4; i++) begin
        if (sync2_r[i] == sync3_r[i]) begin
          pin_r[i] <= sync3_r[i];
        end
      end
    end
  end
  assign {sdi_q, ifs_q, pen_q, dev_rst_q} = pin_r;
  // Soft reset only honoured in mixed mode, the one path that needs no pin
  assign clr = !dev_rst_q || (mixed_mode && soft_reset_req);

  // Master clock enable and its phase index; reset aligns every device in a chain
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mclk_cnt_r <= '0;
      mclk_idx_r <= '0;
    end else if (clr) begin
      mclk_cnt_r <= '0;
      mclk_idx_r <= '0;
    end else if (mclk_cnt_r == `CSC_MCLK_DIV_LAST) begin
      mclk_cnt_r <= '0;
      mclk_idx_r <= mclk_idx_r + 8'h01;
    end else begin
      mclk_cnt_r <= mclk_cnt_r + 3'h1;
    end
  end
  assign mclk_en   = (mclk_cnt_r == `CSC_MCLK_DIV_LAST);
  assign mod_en    = mclk_en && (mclk_idx_r[2:0] == `CSC_MOD_PHASE);
  assign sample_en = mclk_en && (mclk_idx_r == `CSC_SAMPLE_LAST);
  assign sclk_rise = mclk_en && !serial_clock;
  assign sclk_fall = mclk_en && serial_clock;

  // Serial clock is master/2, phase fixed by the shared reset release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      serial_clock <= 1'b0;
    end else if (clr) begin
      serial_clock <= 1'b0;
    end else if (mclk_en) begin
      serial_clock <= !serial_clock;
    end
  end

  // Receive: words on the input, counted against the cascade length
  logic [3:0] rx_cnt_r;
  logic       rx_act_r, rx_done;
  csc_word_t  rx_sh_r, dac_word_r;
  logic [3:0] frame_cnt_r;
  logic       dac_load;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_act_r <= 1'b0;
      rx_cnt_r <= '0;
      rx_sh_r  <= '0;
    end else if (clr || !pen_q) begin
      rx_act_r <= 1'b0;
      rx_cnt_r <= '0;
    end else if (sclk_fall) begin
      if (rx_act_r) begin
        rx_sh_r  <= {rx_sh_r[14:0], sdi_q};
        rx_cnt_r <= rx_cnt_r + 4'h1;
        rx_act_r <= (rx_cnt_r != `CSC_BIT_LAST);
      end else if (ifs_q) begin
        rx_act_r <= 1'b1;
        rx_cnt_r <= '0;
      end
    end
  end
  assign rx_done  = sclk_fall && rx_act_r && (rx_cnt_r == `CSC_BIT_LAST) && pen_q && !clr;
  assign dac_load = rx_done && (frame_cnt_r == {1'b0, cascade_length_field});

  // A completed word beats the sample boundary so a late last word still counts
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frame_cnt_r <= '0;
    end else if (clr) begin
      frame_cnt_r <= '0;
    end else if (rx_done) begin
      frame_cnt_r <= (frame_cnt_r == 4'hf) ? frame_cnt_r : frame_cnt_r + 4'h1;
    end else if (sample_en) begin
      frame_cnt_r <= '0;
    end
  end

  // Host may update less often than every sample; the last word is kept
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dac_word_r <= '0;
    end else if (clr) begin
      dac_word_r <= '0;
    end else if (dac_load) begin
      dac_word_r <= {rx_sh_r[14:0], sdi_q};
    end
  end

  // Encoder decimator
  csc_word_t adc_word;
  logic      adc_valid;
  csc_sinc3_dec u_dec (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .clr       (clr),
    .in_en     (mod_en),
    .bit_in    (adc_bitstream),
    .out_en    (sample_en),
    .out_word  (adc_word),
    .out_valid (adc_valid)
  );

  // Transmit: own word first, then upstream traffic delayed one word slot
  csc_ser_s [`CSC_CHAIN_SLOTS-1:0] chain_r;
  csc_tx_e    tx_st_r;
  csc_word_t  tx_sh_r;
  logic [3:0] tx_cnt_r;
  logic       tx_pend_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chain_r <= '0;
    end else if (clr || !pen_q) begin
      chain_r <= '0;
    end else if (sclk_fall) begin
      chain_r <= {chain_r[`CSC_CHAIN_SLOTS-2:0], ifs_q, sdi_q};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_pend_r <= 1'b0;
      tx_sh_r   <= '0;
    end else if (clr || !pen_q) begin
      tx_pend_r <= 1'b0;
    end else if (adc_valid) begin
      tx_pend_r <= 1'b1;
      tx_sh_r   <= adc_word;
    end else if (sclk_rise && tx_st_r == CSC_TX_IDLE) begin
      tx_pend_r <= 1'b0;
    end
  end

  // Port disabled holds the outputs low and drops any word in flight
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_r         <= CSC_TX_IDLE;
      tx_cnt_r        <= '0;
      serial_data_out <= 1'b0;
      out_frame_sync  <= 1'b0;
    end else if (clr || !pen_q) begin
      tx_st_r         <= CSC_TX_IDLE;
      tx_cnt_r        <= '0;
      serial_data_out <= 1'b0;
      out_frame_sync  <= 1'b0;
    end else if (sclk_rise) begin
      case (tx_st_r)
        CSC_TX_IDLE: begin
          if (tx_pend_r && !adc_valid) begin
            out_frame_sync  <= 1'b1;
            serial_data_out <= 1'b0;
            tx_cnt_r        <= `CSC_BIT_LAST;
            tx_st_r         <= CSC_TX_DATA;
          end else begin
            out_frame_sync  <= chain_r[`CSC_CHAIN_SLOTS-1].fsync;
            serial_data_out <= chain_r[`CSC_CHAIN_SLOTS-1].data;
          end
        end
        CSC_TX_DATA: begin
          out_frame_sync  <= 1'b0;
          serial_data_out <= tx_sh_r[tx_cnt_r];
          tx_cnt_r        <= tx_cnt_r - 4'h1;
          if (tx_cnt_r == 4'h0) begin
            tx_st_r <= CSC_TX_IDLE;
          end
        end
        default: tx_st_r <= CSC_TX_IDLE;
      endcase
    end
  end

  // Decoder interpolator: combs at sample rate, zero-stuffed integrators at 2.048 MHz
  logic [`CSC_INT_W-1:0] xin, c1, c2, c3, x1_r, c1d_r, c2d_r, c3_r;
  logic [`CSC_INT_W-1:0] i1_r, i2_r, i3_r, stuff;
  logic                  stuff_pend_r;
  assign xin   = {{(`CSC_INT_W-16){dac_word_r[15]}}, dac_word_r};
  assign c1    = xin - x1_r;
  assign c2    = c1 - c1d_r;
  assign c3    = c2 - c2d_r;
  assign stuff = stuff_pend_r ? c3_r : '0;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      x1_r         <= '0;
      c1d_r        <= '0;
      c2d_r        <= '0;
      c3_r         <= '0;
      stuff_pend_r <= 1'b0;
    end else if (clr) begin
      x1_r         <= '0;
      c1d_r        <= '0;
      c2d_r        <= '0;
      c3_r         <= '0;
      stuff_pend_r <= 1'b0;
    end else if (sample_en) begin
      x1_r         <= xin;
      c1d_r        <= c1;
      c2d_r        <= c2;
      c3_r         <= c3;
      stuff_pend_r <= 1'b1;
    end else if (mod_en) begin
      stuff_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      i1_r       <= '0;
      i2_r       <= '0;
      i3_r       <= '0;
      dsm_input  <= '0;
      dsm_strobe <= 1'b0;
    end else if (clr) begin
      i1_r       <= '0;
      i2_r       <= '0;
      i3_r       <= '0;
      dsm_input  <= '0;
      dsm_strobe <= 1'b0;
    end else begin
      dsm_strobe <= mod_en;
      if (mod_en) begin
        i1_r <= i1_r + stuff;
        i2_r <= i2_r + i1_r;
        i3_r <= i3_r + i2_r;
        // Bypass cuts delay but repeats each sample, so images are stronger
        dsm_input <= interp_bypass ? dac_word_r
                                   : i3_r[`CSC_INT_W-1:`CSC_INT_SHIFT];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      preamp_enable <= 1'b0;
      preamp_gain   <= '0;
    end else begin
      preamp_enable <= |input_gain_select;
      preamp_gain   <= input_gain_select;
    end
  end

  // Checker helpers
  logic [10:0] gap_r;
  logic        gap_seen_r;
  logic [5:0]  mod_n_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gap_r      <= '0;
      gap_seen_r <= 1'b0;
      mod_n_r    <= '0;
    end else begin
      gap_r      <= sample_en ? 11'h000 : gap_r + 11'h001;
      gap_seen_r <= (gap_seen_r || sample_en) && !clr;
      mod_n_r    <= sample_en ? {5'h00, mod_en} : mod_n_r + {5'h00, mod_en};
    end
  end

  chk_sample_period: assert property (
    @(posedge clk_sys) disable iff (!rst_n || clr)
    (sample_en && gap_seen_r) |-> (gap_r == 11'd1535))
    else $error("sample period is not 256 master clocks");
  chk_decim_ratio: assert property (
    @(posedge clk_sys) disable iff (!rst_n || clr)
    (sample_en && gap_seen_r) |-> (mod_n_r == 6'h20))
    else $error("decimation ratio is not 32");
  chk_interp_strobe: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    dsm_strobe |-> $past(mod_en) ##1 !dsm_strobe[*5])
    else $error("modulator strobe off its 2.048 MHz slot");
  chk_bypass_value: assert property (
    @(posedge clk_sys) disable iff (!rst_n || clr)
    (dsm_strobe && $past(interp_bypass)) |-> (dsm_input == $past(dac_word_r)))
    else $error("bypass did not pass the DAC word");
  chk_dac_hold: assert property (
    @(posedge clk_sys) disable iff (!rst_n || clr)
    !dac_load |=> $stable(dac_word_r))
    else $error("DAC word changed without a load");
  chk_soft_reset: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (mixed_mode && soft_reset_req) |=> (mclk_idx_r == 8'h00 && !serial_clock))
    else $error("mixed mode soft reset not applied");
  chk_sclk_phase: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $changed(serial_clock) |-> ($past(mclk_en) || $past(clr)) && (mclk_cnt_r == 3'h0))
    else $error("serial clock edge off master clock phase");
  chk_gain_map: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ##1 (preamp_gain == $past(input_gain_select)) && (preamp_enable == |preamp_gain))
    else $error("preamp setting does not follow gain select");
  chk_dac_count: assert property (
    @(posedge clk_sys) disable iff (!rst_n || clr)
    dac_load |-> (frame_cnt_r[2:0] == cascade_length_field) ##1 (frame_cnt_r != 4'h0))
    else $error("DAC loaded on wrong frame count");
  chk_frame_width: assert property (
    @(posedge clk_sys) disable iff (!rst_n || clr || !pen_q)
    (sclk_rise && tx_st_r == CSC_TX_IDLE && tx_pend_r && !adc_valid)
      |=> out_frame_sync[*8] ##1 out_frame_sync[*4] ##1 !out_frame_sync
          ##0 (serial_data_out == tx_sh_r[15]))
    else $error("frame sync not one bit ahead of MSB");
endmodule : csc_core
`default_nettype wire

// >>> hdl/csc_consts.svh
// Timing counts and field widths for the codec serial cascade core
`ifndef CSC_CONSTS_SVH
`define CSC_CONSTS_SVH
`define CSC_CLK_PERIOD_NS   10
`define CSC_MCLK_DIV        3'd6
`define CSC_MCLK_DIV_LAST   3'd5
`define CSC_SAMPLE_LAST     8'hff
`define CSC_MOD_PHASE       3'h7
`define CSC_RATE_FACTOR     32
`define CSC_WORD_BITS       16
`define CSC_BIT_LAST        4'hf
`define CSC_CHAIN_SLOTS     17
`define CSC_SCLK_HALF_CYC   6
`define CSC_SAMPLE_CYC      1536
`define CSC_DEC_W           17
`define CSC_INT_W           26
`define CSC_INT_SHIFT       10
`define CSC_PIN_IDLE        4'h3
`endif

// >>> hdl/csc_pkg.sv
// Types shared by the codec serial cascade core
package csc_pkg;
  typedef struct packed {
    logic fsync;
    logic data;
  } csc_ser_s;

  typedef enum logic [0:0] {
    CSC_TX_IDLE,
    CSC_TX_DATA
  } csc_tx_e;

  typedef logic [15:0] csc_word_t;
endpackage : csc_pkg

// >>> hdl/csc_sinc3_dec.sv
// Third-order sinc decimator for the encoder bitstream
`timescale 1ns/1ns
`default_nettype none
`include "csc_consts.svh"
module csc_sinc3_dec
  import csc_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire logic      rst_n,
  input  wire logic      clr,
  input  wire logic      in_en,
  input  wire logic      bit_in,
  input  wire logic      out_en,
  output var csc_word_t  out_word,
  output logic           out_valid
);
  logic [`CSC_DEC_W-1:0] i1_r, i2_r, i3_r;
  logic [`CSC_DEC_W-1:0] d1_r, d2_r, d3_r;
  logic [`CSC_DEC_W-1:0] x, c1, c2, c3;

  // Bitstream maps to +1 or -1; wrapping sums are harmless in a sinc structure
  assign x  = bit_in ? `CSC_DEC_W'(1) : {`CSC_DEC_W{1'b1}};
  assign c1 = i3_r - d1_r;
  assign c2 = c1 - d2_r;
  assign c3 = c2 - d3_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      i1_r <= '0;
      i2_r <= '0;
      i3_r <= '0;
    end else if (clr) begin
      i1_r <= '0;
      i2_r <= '0;
      i3_r <= '0;
    end else if (in_en) begin
      i1_r <= i1_r + x;
      i2_r <= i2_r + i1_r;
      i3_r <= i3_r + i2_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      d1_r      <= '0;
      d2_r      <= '0;
      d3_r      <= '0;
      out_word  <= '0;
      out_valid <= 1'b0;
    end else if (clr) begin
      d1_r      <= '0;
      d2_r      <= '0;
      d3_r      <= '0;
      out_word  <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= out_en;
      if (out_en) begin
        d1_r     <= i3_r;
        d2_r     <= c1;
        d3_r     <= c2;
        out_word <= c3[`CSC_DEC_W-1:1];
      end
    end
  end
endmodule : csc_sinc3_dec
`default_nettype wire

// >>> tb/csc_host_model.sv
// Host serial port model that sends framed words to the codec
`timescale 1ns/1ns
`default_nettype none
module csc_host_model
  import csc_pkg::*;
(
  input  wire logic    serial_clock,
  output var csc_ser_s host_tx
);
  initial host_tx = '0;

  // Drives on the codec's clock rise so the codec samples settled bits on its fall
  task automatic send_word(input csc_word_t w);
    @(posedge serial_clock);
    host_tx <= '{fsync: 1'b1, data: 1'b0};
    for (int i = 15; i >= 0; i--) begin
      @(posedge serial_clock);
      host_tx <= '{fsync: 1'b0, data: w[i]};
    end
    // Gap slot; a released line must not keep showing the last bit
    @(posedge serial_clock);
    host_tx <= '{fsync: 1'b0, data: ~w[0]};
  endtask : send_word
endmodule : csc_host_model
`default_nettype wire

// >>> tb/codec_serial_cascade_core_tb.sv
// Self-checking bench for the codec serial cascade core
`timescale 1ns/1ns
`default_nettype none
`include "csc_consts.svh"
module codec_serial_cascade_core_tb;
  import csc_pkg::*;
  logic       clk_sys              = 1'b0;
  logic       rst_n                = 1'b0;
  logic       port_enable_pin      = 1'b1;
  logic       device_reset_n       = 1'b1;
  logic       adc_bitstream        = 1'b0;
  logic [2:0] input_gain_select    = 3'h0;
  logic [2:0] cascade_length_field = 3'h0;
  logic       interp_bypass        = 1'b1;
  logic       mixed_mode           = 1'b0;
  logic       soft_reset_req       = 1'b0;
  logic       serial_clock;
  logic       serial_data_out;
  logic       out_frame_sync;
  logic       dsm_strobe;
  logic       preamp_enable;
  logic [2:0] preamp_gain;
  csc_word_t  dsm_input;
  csc_word_t  held_w;
  csc_ser_s   host_tx;
  int         failures = 0;
  int         n_tests  = 0;
  int         cycles   = 0;

  always #(`CSC_CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;

  csc_core dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .serial_data_in(host_tx.data),
    .in_frame_sync(host_tx.fsync), .port_enable_pin(port_enable_pin),
    .device_reset_n(device_reset_n), .adc_bitstream(adc_bitstream),
    .input_gain_select(input_gain_select), .cascade_length_field(cascade_length_field),
    .interp_bypass(interp_bypass), .mixed_mode(mixed_mode),
    .soft_reset_req(soft_reset_req), .serial_clock(serial_clock),
    .serial_data_out(serial_data_out), .out_frame_sync(out_frame_sync),
    .dsm_input(dsm_input), .dsm_strobe(dsm_strobe), .preamp_enable(preamp_enable),
    .preamp_gain(preamp_gain)
  );

  csc_host_model host_u (.serial_clock(serial_clock), .host_tx(host_tx));

  task automatic print_verdict();
    $display("counts: comparisons=%0d mismatches=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // Hang guard; the whole run needs roughly 29000 cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    adc_bitstream <= ~adc_bitstream;
    if (cycles == 50000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wait_fs();
    while (out_frame_sync === 1'b1) tick(1);
    while (out_frame_sync !== 1'b1) tick(1);
  endtask : wait_fs

  task automatic wait_strobe();
    while (dsm_strobe !== 1'b1) tick(1);
  endtask : wait_strobe

  task automatic t_gain();
    for (int g = 0; g < 8; g++) begin
      @(posedge clk_sys);
      input_gain_select <= 3'(g);
      tick(3);
      cmp({13'h0, preamp_gain}, 16'(g));
      cmp({15'h0, preamp_enable}, 16'(g != 0));
    end
    $display("test gain done");
  endtask : t_gain

  task automatic t_frame();
    int per;
    int hi;
    wait_fs();
    per = 0;
    while (out_frame_sync === 1'b1) begin
      tick(1);
      per++;
    end
    hi = per;
    while (out_frame_sync !== 1'b1) begin
      tick(1);
      per++;
    end
    cmp(16'(hi), 16'd12);
    cmp(16'(per), 16'd1536);
    while (serial_clock !== 1'b1) tick(1);
    hi = 0;
    while (serial_clock === 1'b1) begin
      tick(1);
      hi++;
    end
    cmp(16'(hi), 16'd6);
    wait_strobe();
    tick(1);
    per = 1;
    while (dsm_strobe !== 1'b1) begin
      tick(1);
      per++;
    end
    cmp(16'(per), 16'd48);
    $display("test frame done");
  endtask : t_frame

  // One word past the chosen index is sent too; it must not reach the DAC
  task automatic t_dac(input logic [2:0] len, output csc_word_t w);
    @(posedge clk_sys);
    cascade_length_field <= len;
    wait_fs();
    for (int k = 0; k <= len + 1; k++) host_u.send_word(16'ha5c3 ^ 16'(k * 16'h1111));
    w = 16'ha5c3 ^ 16'(len * 16'h1111);
    wait_strobe();
    tick(2);
    cmp(dsm_input, w);
    tick(2000);
    wait_strobe();
    tick(2);
    cmp(dsm_input, w);
    $display("test dac len %0d done", len);
  endtask : t_dac

  // Interpolator DC gain is 1024, so the top bits settle exactly on the held word
  task automatic t_interp(input csc_word_t held);
    @(posedge clk_sys);
    interp_bypass <= 1'b0;
    tick(9300);
    wait_strobe();
    tick(2);
    cmp(dsm_input, held);
    @(posedge clk_sys);
    interp_bypass <= 1'b1;
    $display("test interp done");
  endtask : t_interp

  // A host word at index 0 is passed on after the own word, not loaded
  task automatic t_chain();
    csc_word_t got;
    got = '0;
    wait_fs();
    fork
      host_u.send_word(16'h3c5a);
      begin
        wait_fs();
        for (int i = 15; i >= 0; i--) begin
          tick(12);
          got[i] = serial_data_out;
        end
      end
    join
    cmp(got, 16'h3c5a);
    $display("test chain done");
  endtask : t_chain

  task automatic t_disable();
    logic seen;
    @(posedge clk_sys);
    port_enable_pin <= 1'b0;
    tick(10);
    seen = 1'b0;
    repeat (1600) begin
      tick(1);
      seen = seen | out_frame_sync | serial_data_out;
    end
    cmp({15'h0, seen}, 16'h0);
    @(posedge clk_sys);
    port_enable_pin <= 1'b1;
    wait_fs();
    $display("test disable done");
  endtask : t_disable

  task automatic t_reset(input csc_word_t held);
    csc_word_t w;
    @(posedge clk_sys);
    soft_reset_req <= 1'b1;
    tick(100);
    cmp(dsm_input, held);
    @(posedge clk_sys);
    mixed_mode <= 1'b1;
    tick(100);
    cmp(dsm_input, 16'h0);
    @(posedge clk_sys);
    mixed_mode <= 1'b0;
    soft_reset_req <= 1'b0;
    t_dac(3'h0, w);
    @(posedge clk_sys);
    device_reset_n <= 1'b0;
    tick(100);
    cmp(dsm_input, 16'h0);
    @(posedge clk_sys);
    device_reset_n <= 1'b1;
    tick(10);
    $display("test reset done");
  endtask : t_reset

  initial begin
    tick(3);
    cmp({12'h0, serial_clock, out_frame_sync, serial_data_out, dsm_strobe}, 16'h0);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    t_gain();
    t_frame();
    t_dac(3'h0, held_w);
    t_dac(3'h2, held_w);
    t_interp(held_w);
    t_chain();
    t_reset(held_w);
    t_disable();
    print_verdict();
  end
endmodule : codec_serial_cascade_core_tb
`default_nettype wire
